// ===== core/lpm_defs.svh
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
`define AUX_CONTROL_IDX 8'h8e
`define AUX_CONTROL_ADDR 12'h238
`define MODE_CTRL_ADDR 12'h000
`define MODE_STAT_ADDR 12'h004
`define AUX_CONTROL_RST 8'h00
`define MODE_CTRL_RST 8'h00
`define AUX_ALE_OFF_BIT 0
`define CTRL_IDLE_BIT 0
`define CTRL_PD_BIT 1
`define CTRL_CA_IDLE_RUN_BIT 2
`define STATES_PER_CYCLE 6
`define RESET_HOLD_CYCLES 2
`define IDLE_RESET_GRACE 2
`endif

// ===== core/lpm_pkg.sv
package lpm_pkg;
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_idle = 3'b001,
    st_pdown = 3'b010,
    st_grace = 3'b011,
    st_emul = 3'b100
  } mode_t;
  typedef struct packed {
    logic ale;
    logic ale_oe;
    logic prog_read_strobe;
    logic strobe_oe;
    logic port0_float;
    logic port2_addr;
  } pins_t;
  typedef struct packed {
    logic fetch;
    logic data_access;
  } bus_req_t;
endpackage

// ===== core/low_power_mode_pin_control.sv
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "lpm_defs.svh"
module low_power_mode_pin_control #(
  parameter int STATES = `STATES_PER_CYCLE
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reset_pin,
  input wire logic external_fetch_select,
  input wire logic lock_bit_set,
  input wire logic ale_pin_in,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic irq_zero_armed,
  input wire logic irq_one_armed,
  input wire logic enabled_irq,
  input wire lpm_pkg::bus_req_t bus_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output lpm_pkg::pins_t pins,
  output logic osc_run,
  output logic cpu_run,
  output logic counter_array_run,
  output logic ram_write_block,
  output logic core_reset,
  output logic resume_after_pd,
  output logic fetch_external
);
  import lpm_pkg::*;

  if (STATES != 6) begin : g_bad_states
    $error("machine cycle must be six state pairs");
  end

  mode_t mode_reg, mode_next;
  logic half_reg;
  logic [2:0] state_reg;
  logic [7:0] aux_reg;
  logic [7:0] ctrl_reg;
  logic fetch_latch_reg;
  logic strap_taken_reg;
  logic [2:0] rst_cnt_reg;
  logic rst_prev_reg;
  logic emul_req_reg;
  logic data_cyc_reg;
  logic [1:0] grace_reg;
  logic pd_woken_reg;
  logic ale_q_reg, prog_read_strobe_q_reg;

  wire osc_on = mode_reg != st_pdown || pd_woken_reg;
  wire tick = clk_en && half_reg && osc_on;
  wire cycle_end = tick && (state_reg == 3'(STATES - 1));
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_aux = paddr == `AUX_CONTROL_ADDR;
  wire hit_ctrl = paddr == `MODE_CTRL_ADDR;
  wire hit_stat = paddr == `MODE_STAT_ADDR;
  wire hit_any = hit_aux || hit_ctrl || hit_stat;
  wire rst_long = rst_cnt_reg >= 3'(`RESET_HOLD_CYCLES);
  wire pd_wake = (ext_irq_zero == 1'b0 && irq_zero_armed)
              || (ext_irq_one == 1'b0 && irq_one_armed);
  wire pd_release = pd_woken_reg && ext_irq_zero && ext_irq_one;
  wire strap_now = strap_taken_reg ? fetch_latch_reg : !external_fetch_select;
  wire ext_mode = lock_bit_set ? fetch_latch_reg : !external_fetch_select;
  wire ale_slot = (state_reg == 3'd1) || (state_reg == 3'd4);
  wire prog_read_strobe_slot = (state_reg == 3'd3) || (state_reg == 3'd0);
  wire data_skip = data_cyc_reg && (state_reg >= 3'd3 || state_reg == 3'd0);
  wire ale_run = ale_slot && !(data_cyc_reg && state_reg == 3'd1)
              && !(aux_reg[`AUX_ALE_OFF_BIT] && bus_req.fetch);
  wire prog_read_strobe_run = ext_mode && prog_read_strobe_slot && !(data_cyc_reg && prog_read_strobe_slot);
  wire unused = data_skip ^ strap_now ^ rd_en ^ (|pwdata[31:8]);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else if (clk_en && osc_on) begin
      half_reg <= !half_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= 3'h0;
    end else if (tick && osc_on) begin
      state_reg <= cycle_end ? 3'h0 : state_reg + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_cyc_reg <= 1'b0;
    end else if (cycle_end) begin
      data_cyc_reg <= bus_req.data_access && mode_reg == st_run;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (!reset_pin) begin
        rst_cnt_reg <= 3'h0;
      end else if (cycle_end && !rst_long) begin
        rst_cnt_reg <= rst_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b0;
      emul_req_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
      fetch_latch_reg <= 1'b0;
    end else if (clk_en) begin
      rst_prev_reg <= rst_long;
      if (rst_long) begin
        emul_req_reg <= !ale_pin_in && (pins.prog_read_strobe || !pins.strobe_oe);
        strap_taken_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        fetch_latch_reg <= !external_fetch_select;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_woken_reg <= 1'b0;
    end else if (clk_en) begin
      if (mode_reg != st_pdown) begin
        pd_woken_reg <= 1'b0;
      end else if (pd_wake) begin
        pd_woken_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      st_run: begin
        if (ctrl_reg[`CTRL_PD_BIT]) begin
          mode_next = st_pdown;
        end else if (ctrl_reg[`CTRL_IDLE_BIT]) begin
          mode_next = st_idle;
        end
      end
      st_idle: begin
        if (reset_pin) begin
          mode_next = st_grace;
        end else if (enabled_irq) begin
          mode_next = st_run;
        end
      end
      st_pdown: begin
        if (reset_pin || pd_release) begin
          mode_next = st_run;
        end
      end
      st_grace: begin
        if (grace_reg == 2'(`IDLE_RESET_GRACE - 1) && cycle_end) begin
          mode_next = st_run;
        end
      end
      st_emul: mode_next = st_emul;
      default: mode_next = st_run;
    endcase
    if (rst_prev_reg && !rst_long) begin
      mode_next = emul_req_reg ? st_emul : st_run;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= st_run;
      grace_reg <= 2'h0;
      resume_after_pd <= 1'b0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      grace_reg <= (mode_reg != st_grace) ? 2'h0 : grace_reg + 2'(cycle_end);
      resume_after_pd <= mode_reg == st_pdown && pd_release && !reset_pin;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= `AUX_CONTROL_RST;
      ctrl_reg <= `MODE_CTRL_RST;
    end else if (clk_en) begin
      if (rst_long) begin
        aux_reg <= `AUX_CONTROL_RST;
        ctrl_reg <= `MODE_CTRL_RST;
      end else begin
        if (wr_en && hit_aux) begin
          aux_reg <= {7'h00, pwdata[`AUX_ALE_OFF_BIT]};
        end
        if (wr_en && hit_ctrl) begin
          ctrl_reg <= pwdata[7:0];
        end else if (mode_reg != st_run) begin
          ctrl_reg[`CTRL_IDLE_BIT] <= 1'b0;
          ctrl_reg[`CTRL_PD_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= hit_aux ? {24'h00_0000, aux_reg}
              : hit_ctrl ? {24'h00_0000, ctrl_reg}
              : hit_stat ? {26'h000_0000, fetch_latch_reg, ext_mode, 1'b0, mode_reg}
              : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ale_q_reg <= 1'b0;
      prog_read_strobe_q_reg <= 1'b1;
    end else if (clk_en) begin
      case (mode_reg)
        st_run, st_grace: begin
          ale_q_reg <= ale_run;
          prog_read_strobe_q_reg <= !prog_read_strobe_run;
        end
        st_idle: begin
          ale_q_reg <= 1'b1;
          prog_read_strobe_q_reg <= 1'b1;
        end
        st_pdown: begin
          ale_q_reg <= 1'b0;
          prog_read_strobe_q_reg <= 1'b0;
        end
        st_emul: begin
          ale_q_reg <= 1'b1;
          prog_read_strobe_q_reg <= 1'b1;
        end
        default: begin
          ale_q_reg <= 1'b0;
          prog_read_strobe_q_reg <= 1'b1;
        end
      endcase
    end
  end

  assign pins.ale = ale_q_reg;
  assign pins.prog_read_strobe = prog_read_strobe_q_reg;
  assign pins.ale_oe = mode_reg != st_emul && !rst_long
                    && !(aux_reg[`AUX_ALE_OFF_BIT] && mode_reg == st_run && bus_req.fetch);
  assign pins.strobe_oe = mode_reg != st_emul && !rst_long;
  assign pins.port0_float = mode_reg == st_emul || ((mode_reg == st_idle
                         || mode_reg == st_pdown) && ext_mode);
  assign pins.port2_addr = mode_reg == st_idle && ext_mode;
  assign osc_run = osc_on;
  assign cpu_run = mode_reg == st_run || mode_reg == st_grace || mode_reg == st_emul;
  assign counter_array_run = mode_reg == st_run
                          || (mode_reg == st_idle && ctrl_reg[`CTRL_CA_IDLE_RUN_BIT]);
  assign ram_write_block = mode_reg == st_grace;
  assign core_reset = rst_long;
  assign fetch_external = ext_mode;

  property p_pd_strobes_low;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_pdown && clk_en) |=> (!pins.ale && !pins.prog_read_strobe) || !clk_en;
  endproperty
  a_pd_strobes_low: assert property (p_pd_strobes_low)
    else $error("strobes not low in power-down");

  property p_idle_strobes_high;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_idle && $past(mode_reg) == st_idle) |-> pins.ale && pins.prog_read_strobe;
  endproperty
  a_idle_strobes_high: assert property (p_idle_strobes_high)
    else $error("strobes not high in idle");

  property p_osc_stops;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_pdown && !pd_woken_reg) |-> !osc_run && !cpu_run;
  endproperty
  a_osc_stops: assert property (p_osc_stops)
    else $error("oscillator runs in power-down");

  property p_pd_wake_osc;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_pdown && pd_woken_reg) |-> osc_run && !cpu_run;
  endproperty
  a_pd_wake_osc: assert property (p_pd_wake_osc)
    else $error("oscillator not restarted on wake");

  property p_grace_block;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_idle && reset_pin && clk_en && !(rst_prev_reg && !rst_long))
        |=> ram_write_block;
  endproperty
  a_grace_block: assert property (p_grace_block)
    else $error("ram writes not blocked after idle reset");

  property p_emul_float;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_emul) |-> pins.port0_float && !pins.strobe_oe;
  endproperty
  a_emul_float: assert property (p_emul_float)
    else $error("emulation pins not released");

  property p_irq_idle_exit;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_idle && enabled_irq && !reset_pin && clk_en && !rst_prev_reg)
        |=> mode_reg == st_run;
  endproperty
  a_irq_idle_exit: assert property (p_irq_idle_exit)
    else $error("idle not left on interrupt");

  property p_ca_pause;
    @(posedge clock) disable iff (!rst_n)
      (mode_reg == st_idle && !ctrl_reg[`CTRL_CA_IDLE_RUN_BIT]) |-> !counter_array_run;
  endproperty
  a_ca_pause: assert property (p_ca_pause)
    else $error("counter array runs in paused idle");

  property p_strap_locked;
    @(posedge clock) disable iff (!rst_n)
      (lock_bit_set && strap_taken_reg && $stable(strap_taken_reg)) |-> $stable(fetch_external);
  endproperty
  a_strap_locked: assert property (p_strap_locked)
    else $error("locked fetch select changed");
endmodule

// ===== tb/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
  input wire logic clock,
  input wire lpm_pkg::pins_t pins,
  input wire logic emul_req,
  input wire logic clr,
  output logic ale_pin_in,
  output int ale_cnt,
  output int strobe_cnt
);
  import lpm_pkg::*;
  logic ale_prev;
  logic strobe_prev;
  // emulator pulls the latch pin low, otherwise weak pull-up when released
  assign ale_pin_in = emul_req ? 1'b0 : (pins.ale_oe ? pins.ale : 1'b1);
  always_ff @(posedge clock) begin
    ale_prev <= ale_pin_in;
    strobe_prev <= pins.prog_read_strobe;
    if (clr) begin
      ale_cnt <= 0;
      strobe_cnt <= 0;
    end else begin
      if (ale_pin_in && !ale_prev)
        ale_cnt <= ale_cnt + 1;
      if (!pins.prog_read_strobe && strobe_prev)
        strobe_cnt <= strobe_cnt + 1;
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "lpm_defs.svh"
module tb;
  import lpm_pkg::*;
  logic clock, rst_n, clk_en, reset_pin, external_fetch_select, lock_bit_set;
  logic ext_irq_zero, ext_irq_one, irq_zero_armed, irq_one_armed, enabled_irq;
  logic psel, penable, pwrite, emul_req, clr, ale_pin_in, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic pready, pslverr, osc_run, cpu_run, counter_array_run, ram_write_block;
  logic core_reset, resume_after_pd, fetch_external;
  bus_req_t bus_req;
  pins_t pins;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int ale_cnt, strobe_cnt, k, n;
  low_power_mode_pin_control low_power_mode_pin_control_inst (.clock, .rst_n, .clk_en,
    .reset_pin, .external_fetch_select, .lock_bit_set, .ale_pin_in, .ext_irq_zero,
    .ext_irq_one, .irq_zero_armed, .irq_one_armed, .enabled_irq, .bus_req, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .osc_run,
    .cpu_run, .counter_array_run, .ram_write_block, .core_reset, .resume_after_pd,
    .fetch_external);
  ext_mem_model ext_mem_model_inst (.clock, .pins, .emul_req, .clr, .ale_pin_in,
    .ale_cnt, .strobe_cnt);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // count latch pulses and read strobes over 121 clocks after a one-clock clear
  task automatic win(input int ea, input int es);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (121) @(posedge clock);
    chk("ale pulses", ea, ale_cnt);
    chk("read strobes", es, strobe_cnt);
  endtask
  task automatic rst_pulse;
    reset_pin <= 1'b1;
    repeat (30) @(posedge clock);
    reset_pin <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, reset_pin, external_fetch_select, lock_bit_set, irq_zero_armed} = '0;
    {psel, penable, pwrite, emul_req, clr, enabled_irq, irq_one_armed} = '0;
    {clk_en, ext_irq_zero, ext_irq_one} = 3'b111;
    {bus_req, paddr, pwdata} = '0;
    void'($urandom(32'h76a6));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, `AUX_CONTROL_ADDR, 0);
    chk("aux reset", `AUX_CONTROL_RST, rd);
    apb(0, 12'h0f0, 0);
    chk("unmapped error", 1, err);
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      apb(1, `AUX_CONTROL_ADDR, d);
      apb(0, `AUX_CONTROL_ADDR, 0);
      chk("aux readback", 32'(d[`AUX_ALE_OFF_BIT]), rd);
    end
    $display("test registers done");
    apb(1, `AUX_CONTROL_ADDR, 0);
    repeat (24) @(posedge clock);
    win(20, 20);
    bus_req <= 2'b01;
    repeat (24) @(posedge clock);
    win(10, 0);
    bus_req <= 2'b10;
    apb(1, `AUX_CONTROL_ADDR, 1);
    repeat (24) @(posedge clock);
    chk("ale drive off", 0, pins.ale_oe);
    win(0, 20);
    apb(1, `AUX_CONTROL_ADDR, 0);
    repeat (24) @(posedge clock);
    win(20, 20);
    $display("test strobes done");
    for (k = 0; k < 2; k++) begin
      apb(1, `MODE_CTRL_ADDR, k * 4 + 1);
      repeat (30) @(posedge clock);
      chk("idle pins", {4'hf, 1'b0, k[0]}, {pins.ale, pins.prog_read_strobe,
        pins.port0_float, pins.port2_addr, cpu_run, counter_array_run});
      apb(0, `MODE_STAT_ADDR, 0);
      chk("idle mode", 1, rd[2:0]);
      enabled_irq <= 1'b1;
      repeat (30) @(posedge clock);
      chk("idle exit", 1, cpu_run);
      apb(1, `MODE_CTRL_ADDR, 0);
      enabled_irq <= 1'b0;
    end
    apb(1, `MODE_CTRL_ADDR, 1);
    repeat (30) @(posedge clock);
    reset_pin <= 1'b1;
    repeat (3) @(posedge clock);
    chk("grace block", 1, ram_write_block);
    rst_pulse();
    chk("grace over", 0, ram_write_block);
    $display("test idle done");
    apb(1, `MODE_CTRL_ADDR, 2);
    repeat (30) @(posedge clock);
    chk("pd pins", 5'b00100, {pins.ale, pins.prog_read_strobe, pins.port0_float,
      pins.port2_addr, osc_run});
    {irq_zero_armed, ext_irq_zero} <= 2'b10;
    repeat (40) @(posedge clock);
    chk("osc restart", 1, osc_run);
    ext_irq_zero <= 1'b1;
    n = 0;
    while (resume_after_pd !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk("resume pulse", 1, resume_after_pd);
    apb(0, `MODE_STAT_ADDR, 0);
    chk("irq exit mode", 0, rd[2:0]);
    apb(1, `AUX_CONTROL_ADDR, 1);
    apb(1, `MODE_CTRL_ADDR, 2);
    repeat (30) @(posedge clock);
    rst_pulse();
    apb(0, `AUX_CONTROL_ADDR, 0);
    chk("reset exit aux", 0, rd[7:0]);
    $display("test power down done");
    {emul_req, lock_bit_set} <= 2'b11;
    rst_pulse();
    apb(0, `MODE_STAT_ADDR, 0);
    chk("emulation mode", 4, rd[2:0]);
    chk("emulation pins", 3'b001, {pins.ale_oe, pins.strobe_oe, pins.port0_float});
    emul_req <= 1'b0;
    rst_pulse();
    apb(0, `MODE_STAT_ADDR, 0);
    chk("normal mode", 0, rd[2:0]);
    external_fetch_select <= 1'b1;
    repeat (2) @(posedge clock);
    chk("latched strap", 1, fetch_external);
    lock_bit_set <= 1'b0;
    repeat (2) @(posedge clock);
    chk("live strap", 0, fetch_external);
    $display("test emulation done");
    give_verdict();
  end
endmodule
